// File: logic/chag_hblank_gen.sv
// Top of the horizontal blank generator with its AXI4-Lite register slave.
// Assumes HD/VD from pins, sequence select and clamp pattern on CLK.
//
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
module chag_hblank_gen (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        LINE_SYNC,
  input  wire logic        FIELD_SYNC,
  input  wire logic        SEQ_SEL,
  input  wire logic        CLAMP_PATTERN,
  output logic             HORIZONTAL_BLANK_WINDOW,
  output logic      [3:0]  HORIZONTAL_CCD_CLOCK,
  output logic             OPTICAL_BLACK_CLAMP,
  output logic             FREEZE_ALLOWED,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  localparam int PW = chag_pkg::PIX_W;
  localparam int LW = chag_pkg::LINE_W;

  logic [PW-1:0] bank_mem [chag_pkg::NUM_SEQ*chag_pkg::BANK_WORDS];
  logic [2:0]    div_reg;
  logic [LW-1:0] mask_first_reg;
  logic [LW-1:0] mask_last_reg;
  logic          aw_full_reg, w_full_reg;
  logic [7:0]    aw_idx_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic          do_write;
  logic          hd_s1, hd_s2, hd_s3, vd_s1, vd_s2, vd_s3;
  logic          line_start, vd_rise, vd_pend_reg;
  logic [LW-1:0] line_reg, line_next;
  logic [PW-1:0] pix_reg;
  chag_pkg::chag_tog_set_type  set_reg, set_next;
  chag_pkg::chag_line_cfg_type cfg_reg, cfg_next;
  logic          odd_reg, use_odd_reg, use_odd_next;
  logic          blank_reg, pat_lvl_reg;
  logic [PW-1:0] pat_pos_reg;
  logic [7:0]    rep_cnt_reg;
  logic          pat_mode, in_win, pat_on, hit;

  function automatic logic is_bank(input logic [7:0] idx);
    return idx >= chag_pkg::IDX_BANK_BASE && idx <= chag_pkg::IDX_BANK_END;
  endfunction

  function automatic logic [chag_pkg::BANK_AW-1:0] bank_addr(
    input logic [7:0] idx);
    logic [7:0] off;
    off = idx - chag_pkg::IDX_BANK_BASE;
    return off[chag_pkg::BANK_AW-1:0];
  endfunction

  // Any enabled toggle position equal to the position given
  function automatic logic toggle_hit(input chag_pkg::chag_tog_set_type s,
                                      input logic [PW-1:0] pos);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 6; i++) begin
      h = h | (s.en[i] && s.tog[i] == pos);
    end
    return h;
  endfunction

  // AXI write channel: address and data taken in either order
  assign do_write = aw_full_reg && w_full_reg && !S_AXI_BVALID;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_idx_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= chag_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg   <= 1'b1;
        aw_idx_reg    <= S_AXI_AWADDR[9:2];
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg   <= 1'b1;
        wdata_reg    <= S_AXI_WDATA;
        wstrb_reg    <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (is_bank(aw_idx_reg)
                         || aw_idx_reg == chag_pkg::IDX_CLK_DIV
                         || aw_idx_reg == chag_pkg::IDX_MASK_FIRST
                         || aw_idx_reg == chag_pkg::IDX_MASK_LAST)
                        ? chag_pkg::RESP_OKAY : chag_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Register stores; the byte lane 0 strobe alone gates every field, the 13-bit fields included
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_reg        <= 3'h0;
      mask_first_reg <= chag_pkg::MASK_RESET;
      mask_last_reg  <= chag_pkg::MASK_RESET;
      for (int i = 0; i < chag_pkg::NUM_SEQ*chag_pkg::BANK_WORDS; i++) begin
        bank_mem[i] <= chag_pkg::TOG_RESET;
      end
    end else if (do_write) begin
      if (aw_idx_reg == chag_pkg::IDX_CLK_DIV && wstrb_reg[0]) begin
        div_reg <= wdata_reg[chag_pkg::DIV_MSB:chag_pkg::DIV_LSB];
      end
      if (aw_idx_reg == chag_pkg::IDX_MASK_FIRST && wstrb_reg[0]) begin
        mask_first_reg <= wdata_reg[LW-1:0];
      end
      if (aw_idx_reg == chag_pkg::IDX_MASK_LAST && wstrb_reg[0]) begin
        mask_last_reg <= wdata_reg[LW-1:0];
      end
      if (is_bank(aw_idx_reg) && wstrb_reg[0]) begin
        bank_mem[bank_addr(aw_idx_reg)] <= wdata_reg[PW-1:0];
      end
    end
  end

  // AXI read channel: one read under way, answer one cycle after address
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= chag_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= chag_pkg::RESP_OKAY;
      S_AXI_RDATA   <= 32'h0000_0000;
      if (is_bank(S_AXI_ARADDR[9:2])) begin
        S_AXI_RDATA[PW-1:0] <= bank_mem[bank_addr(S_AXI_ARADDR[9:2])];
      end else begin
        case (S_AXI_ARADDR[9:2])
          chag_pkg::IDX_CLK_DIV: begin
            S_AXI_RDATA[chag_pkg::DIV_MSB:chag_pkg::DIV_LSB] <= div_reg;
          end
          chag_pkg::IDX_MASK_FIRST: S_AXI_RDATA[LW-1:0] <= mask_first_reg;
          chag_pkg::IDX_MASK_LAST:  S_AXI_RDATA[LW-1:0] <= mask_last_reg;
          chag_pkg::IDX_STATUS: begin
            S_AXI_RDATA <= {14'h0000, blank_reg, odd_reg, 4'h0, line_reg};
          end
          default: S_AXI_RRESP <= chag_pkg::RESP_SLVERR;
        endcase
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Pin synchronisers and edge detection
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      {hd_s1, hd_s2, hd_s3} <= 3'h0;
      {vd_s1, vd_s2, vd_s3} <= 3'h0;
    end else begin
      {hd_s1, hd_s2, hd_s3} <= {LINE_SYNC, hd_s1, hd_s2};
      {vd_s1, vd_s2, vd_s3} <= {FIELD_SYNC, vd_s1, vd_s2};
    end
  end
  assign line_start = hd_s2 && !hd_s3;
  assign vd_rise    = vd_s2 && !vd_s3;
  assign line_next  = vd_pend_reg ? '0 : line_reg + 1'b1;

  // Per-line choice of toggle set from the active sequence bank
  always_comb begin
    logic [chag_pkg::BANK_AW-1:0] b;
    logic                         odd;
    b            = {SEQ_SEL, 4'h0};
    odd          = line_next[0];
    cfg_next.alt = bank_mem[b + chag_pkg::W_CFG][2:0];
    cfg_next.pol = bank_mem[b + chag_pkg::W_CFG][chag_pkg::CFG_POL_BIT];
    cfg_next.len = bank_mem[b + chag_pkg::W_LEN];
    cfg_next.rep = bank_mem[b + chag_pkg::W_REP][7:0];
    use_odd_next = odd && cfg_next.alt == chag_pkg::ALT_SPLIT;
    for (int i = 0; i < 6; i++) begin
      set_next.tog[i] = use_odd_next
        ? bank_mem[b + chag_pkg::W_ODD1 + 4'(i)]
        : bank_mem[b + chag_pkg::W_EVEN1 + 4'(i)];
    end
    case (cfg_next.alt)
      chag_pkg::ALT_ODD12: begin
        set_next.en = odd ? chag_pkg::EN_LOW2 : chag_pkg::EN_HIGH4;
      end
      chag_pkg::ALT_EVN12: begin
        set_next.en = odd ? chag_pkg::EN_HIGH4 : chag_pkg::EN_LOW2;
      end
      chag_pkg::ALT_NONE, chag_pkg::ALT_SPLIT: set_next.en = chag_pkg::EN_ALL;
      default: set_next.en = chag_pkg::EN_ALL >> 2;
    endcase
  end

  // Line counter restarts at field start; parity is independent of
  // any vertical alternation elsewhere
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      vd_pend_reg <= 1'b1;
      line_reg    <= '0;
      odd_reg     <= 1'b0;
      set_reg     <= '0;
      cfg_reg     <= '0;
      use_odd_reg <= 1'b0;
    end else if (line_start) begin
      vd_pend_reg <= vd_rise;
      line_reg    <= line_next;
      odd_reg     <= line_next[0];
      set_reg     <= set_next;
      cfg_reg     <= cfg_next;
      use_odd_reg <= use_odd_next;
    end else if (vd_rise) begin
      vd_pend_reg <= 1'b1;
    end
  end

  // Repeat-pattern mode: toggles 5 and 6 bound the window
  assign pat_mode = cfg_reg.alt[2];
  assign in_win   = pix_reg >= set_reg.tog[4] && pix_reg < set_reg.tog[5];
  assign pat_on   = rep_cnt_reg < cfg_reg.rep;
  assign hit      = toggle_hit(set_reg, pat_mode ? pat_pos_reg : pix_reg);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pix_reg     <= '0;
      blank_reg   <= 1'b0;
      pat_pos_reg <= '0;
      rep_cnt_reg <= 8'h00;
      pat_lvl_reg <= 1'b1;
    end else if (line_start) begin
      pix_reg     <= '0;
      blank_reg   <= 1'b0;
      pat_pos_reg <= '0;
      rep_cnt_reg <= 8'h00;
      pat_lvl_reg <= 1'b1;
    end else begin
      pix_reg <= pix_reg + 1'b1;
      if (!pat_mode) begin
        blank_reg <= blank_reg ^ hit;
      end else begin
        blank_reg <= in_win && (pat_on ? pat_lvl_reg ^ hit : 1'b1);
        if (in_win && pat_on) begin
          if (pat_pos_reg + 1'b1 >= cfg_reg.len) begin
            pat_pos_reg <= '0;
            rep_cnt_reg <= rep_cnt_reg + 8'h01;
            pat_lvl_reg <= 1'b1;
          end else begin
            pat_pos_reg <= pat_pos_reg + 1'b1;
            pat_lvl_reg <= pat_lvl_reg ^ hit;
          end
        end
      end
    end
  end

  // Registered outputs: clamp masking and freeze gate
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HORIZONTAL_BLANK_WINDOW <= 1'b0;
      OPTICAL_BLACK_CLAMP     <= 1'b0;
      FREEZE_ALLOWED          <= 1'b1;
    end else begin
      HORIZONTAL_BLANK_WINDOW <= blank_reg;
      OPTICAL_BLACK_CLAMP     <= CLAMP_PATTERN
        && !(line_reg >= mask_first_reg && line_reg <= mask_last_reg);
      FREEZE_ALLOWED <= cfg_reg.alt != chag_pkg::ALT_SPLIT;
    end
  end

  chag_hclk_div u_hclk_div (
    .clk      (CLK),
    .reset    (RESET),
    .in_blank (blank_reg),
    .div_code (div_reg),
    .mask_pol (cfg_reg.pol),
    .h_clk    (HORIZONTAL_CCD_CLOCK)
  );

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_alt1_sets: assert property (line_start && cfg_next.alt == 3'h1
    |=> set_reg.en == (odd_reg ? 6'h03 : 6'h3c))
    else $error("mode 1 set wrong");
  a_alt2_sets: assert property (line_start && cfg_next.alt == 3'h2
    |=> set_reg.en == (odd_reg ? 6'h3c : 6'h03))
    else $error("mode 2 set wrong");
  a_alt3_odd_set: assert property (line_start && cfg_next.alt == 3'h3
    |=> set_reg.en == 6'h3f && use_odd_reg == odd_reg)
    else $error("mode 3 set wrong");
  a_odd_set_gate: assert property (use_odd_reg |-> cfg_reg.alt == 3'h3)
    else $error("odd set used outside mode 3");
  a_pattern_window: assert property (pat_mode && !line_start && !in_win
    |=> !blank_reg) else $error("pattern blank outside window");
  a_div_store: assert property (do_write && aw_idx_reg == 8'h35
    && wstrb_reg[0] |=> div_reg == $past(wdata_reg[6:4]))
    else $error("divider field not stored");
  a_full_rate: assert property (!blank_reg [*3]
    |-> HORIZONTAL_CCD_CLOCK[0] != $past(HORIZONTAL_CCD_CLOCK[0]))
    else $error("clock slowed outside blank");
  a_clamp_mask: assert property (line_reg >= mask_first_reg
    && line_reg <= mask_last_reg |=> !OPTICAL_BLACK_CLAMP)
    else $error("clamp not masked");
  a_line_start_clear: assert property (line_start |=> !blank_reg
    && pix_reg == '0) else $error("line start not clean");
  a_freeze_gate: assert property (cfg_reg.alt == 3'h3 |=> !FREEZE_ALLOWED)
    else $error("freeze allowed in mode 3");
  a_field_restart: assert property (vd_pend_reg && line_start
    |=> line_reg == '0 && !odd_reg) else $error("field restart");

  c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read_done:  cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_odd_split:  cover property (use_odd_reg && blank_reg);
  c_pattern:    cover property (pat_mode && in_win && !blank_reg);
endmodule
`default_nettype wire

// File: logic/chag_pkg.sv
// Constants, register map and carrier types of the horizontal blank generator.
// Assumes one pixel-rate clock and an AXI4-Lite master with 32-bit data.
`default_nettype none
package chag_pkg;
  localparam int PIX_W      = 13;
  localparam int LINE_W     = 12;
  localparam int NUM_SEQ    = 2;
  localparam int BANK_WORDS = 16;
  localparam int BANK_AW    = 5;
  localparam int DIV_LSB    = 4;
  localparam int DIV_MSB    = 6;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_DIV    = 8'h35;
  localparam logic [7:0] IDX_MASK_FIRST = 8'h36;
  localparam logic [7:0] IDX_MASK_LAST  = 8'h37;
  localparam logic [7:0] IDX_STATUS     = 8'h38;
  localparam logic [7:0] IDX_BANK_BASE  = 8'h40;
  localparam logic [7:0] IDX_BANK_END   = 8'h5f;
  // Word offsets inside one sequence bank
  localparam logic [3:0] W_CFG   = 4'h0;
  localparam logic [3:0] W_EVEN1 = 4'h1;
  localparam logic [3:0] W_ODD1  = 4'h7;
  localparam logic [3:0] W_LEN   = 4'hd;
  localparam logic [3:0] W_REP   = 4'he;
  localparam int CFG_POL_BIT = 3;
  localparam logic [PIX_W-1:0]  TOG_RESET  = 13'h1ffd;
  localparam logic [LINE_W-1:0] MASK_RESET = 12'hfff;
  localparam logic [2:0] ALT_NONE  = 3'h0;
  localparam logic [2:0] ALT_ODD12 = 3'h1;
  localparam logic [2:0] ALT_EVN12 = 3'h2;
  localparam logic [2:0] ALT_SPLIT = 3'h3;
  localparam logic [5:0] EN_ALL    = 6'h3f;
  localparam logic [5:0] EN_LOW2   = 6'h03;
  localparam logic [5:0] EN_HIGH4  = 6'h3c;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [5:0][PIX_W-1:0] tog;
    logic [5:0]            en;
  } chag_tog_set_type;

  typedef struct packed {
    logic [2:0]       alt;
    logic             pol;
    logic [PIX_W-1:0] len;
    logic [7:0]       rep;
  } chag_line_cfg_type;
endpackage
`default_nettype wire

// File: logic/chag_hclk_div.sv
// Horizontal CCD clock former: full rate outside blank, divided or masked in it.
// Assumes blank window and settings arrive from logic on the same clock.
`default_nettype none
module chag_hclk_div (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       in_blank,
  input  wire logic [2:0] div_code,
  input  wire logic       mask_pol,
  output logic      [3:0] h_clk
);
  logic [3:0] cnt_reg;
  logic [3:0] half_next;
  logic       phase_reg;

  // Half period in clocks: 1 at pixel rate, 2*code when divided
  always_comb begin
    if (in_blank && div_code != 3'h0) begin
      half_next = {div_code, 1'b0};
    end else begin
      half_next = 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg   <= 4'h0;
      phase_reg <= 1'b0;
    end else if (cnt_reg + 4'h1 >= half_next) begin
      cnt_reg   <= 4'h0;
      phase_reg <= ~phase_reg;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      h_clk <= 4'h0;
    end else if (in_blank && div_code == 3'h0) begin
      h_clk <= {~mask_pol, mask_pol, ~mask_pol, mask_pol};
    end else begin
      h_clk <= {~phase_reg, phase_reg, ~phase_reg, phase_reg};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_div_half_period: assert property (cnt_reg < half_next
    || $past(half_next) != half_next) else $error("divider count overrun");
  a_div_code_two: assert property (in_blank && div_code == 3'h2
    && cnt_reg == 4'h0 && $stable(div_code) |=> cnt_reg == 4'h1)
    else $error("divide by four not counting");
  a_mask_levels: assert property (in_blank && div_code == 3'h0
    |=> h_clk[0] == $past(mask_pol) && h_clk[1] == !$past(mask_pol))
    else $error("blank mask levels wrong");
endmodule
`default_nettype wire

// File: tb/chag_ccd_model.sv
// Far-side model: sensor horizontal register measuring clock 1 pulse widths.
// Assumes clocks and blank window are sampled on the pixel clock.
`default_nettype none
module chag_ccd_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       blank,
  input  wire logic [3:0] h_clk,
  output logic      [3:0] in_max,
  output logic      [3:0] out_max
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev;
  logic       all_in;
  logic       all_out;
  logic [3:0] run;
  // Widest clock 1 high run lying wholly inside or wholly outside blank
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev <= 1'b0;
      run <= 4'h0;
      all_in <= 1'b0;
      all_out <= 1'b0;
      in_max <= 4'h0;
      out_max <= 4'h0;
    end else begin
      prev <= h_clk[0];
      if (h_clk[0] && !prev) begin
        run <= 4'h1;
        all_in <= blank;
        all_out <= !blank;
      end else if (h_clk[0]) begin
        run <= (run == 4'hf) ? run : run + 4'h1;
        all_in <= all_in & blank;
        all_out <= all_out & !blank;
      end
      if (clear) begin
        in_max <= 4'h0;
        out_max <= 4'h0;
      end else if (!h_clk[0] && prev) begin
        if (all_in && run > in_max) in_max <= run;
        if (all_out && run > out_max) out_max <= run;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/test_chag_hblank_gen.sv
// Self-checking bench of the horizontal blank generator.
// Assumes the design and package under logic/ and the sensor model.
`default_nettype none
module test_chag_hblank_gen;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] P   = 13'h1ffd;
  localparam logic [31:0] MA  = 32'hffff_0f03;
  localparam logic [31:0] MCK = 32'hffff_ff03;
  localparam logic [31:0] MIM = 32'hffff_0ff3;
  logic CLK, RESET, LINE_SYNC, FIELD_SYNC, SEQ_SEL, CLAMP_PATTERN;
  logic hbw, frz, obc, line_done;
  logic [3:0] hcc, in_max, out_max, m_r, m_ck, bcnt;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [11:0] m_w;
  logic m_cl, m_fr, pblank;
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];
  logic [12:0] ta [12];
  logic [2:0] code;
  int bad_count, tests_run, cycles, rnd, t1, t2;
  int we[4] = '{60, 40, 20, 60};
  int re[4] = '{3, 2, 1, 3};
  int wo[4] = '{60, 20, 40, 5};
  int ro[4] = '{3, 1, 2, 1};

  chag_hblank_gen dut (.CLK(CLK), .RESET(RESET), .LINE_SYNC(LINE_SYNC),
    .FIELD_SYNC(FIELD_SYNC), .SEQ_SEL(SEQ_SEL),
    .CLAMP_PATTERN(CLAMP_PATTERN), .HORIZONTAL_BLANK_WINDOW(hbw),
    .HORIZONTAL_CCD_CLOCK(hcc), .OPTICAL_BLACK_CLAMP(obc),
    .FREEZE_ALLOWED(frz), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  chag_ccd_model ccd (.clk(CLK), .reset(RESET), .clear(line_done),
    .blank(hbw), .h_clk(hcc), .in_max(in_max), .out_max(out_max));

  initial CLK = 1'b0;
  always #10 CLK = ~CLK;

  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note_exp(input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask

  task automatic pop_cmp(input logic [33:0] got);
    logic [33:0] m;
    if (exp_q.size() == 0) begin
      bad_count++;
      $display("MISMATCH %0t unexpected result %h", $time, got);
    end else begin
      m = msk_q.pop_front();
      check(got & m, exp_q.pop_front() & m);
    end
  endtask

  task automatic axw(input logic [7:0] i, input logic [31:0] d,
                     input logic [1:0] er = 2'h0);
    note_exp({er, 32'h0}, '1);
    @(posedge CLK);
    awaddr <= {22'h0, i, 2'h0};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] i, input logic [33:0] e);
    note_exp(e, '1);
    @(posedge CLK);
    araddr <= {22'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLK);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic cfg(input int s, input logic [3:0] c);
    axw(8'(64 + 16 * s), {28'h0, c});
    for (int i = 0; i < 12; i++) axw(8'(65 + 16 * s + i), {19'h0, ta[i]});
  endtask

  task automatic field();
    @(posedge CLK);
    FIELD_SYNC <= 1'b1;
    repeat (3) @(posedge CLK);
    FIELD_SYNC <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  task automatic line(input logic s, input logic [31:0] e,
                      input logic [31:0] m);
    @(posedge CLK);
    SEQ_SEL <= s;
    LINE_SYNC <= 1'b1;
    repeat (3) @(posedge CLK);
    LINE_SYNC <= 1'b0;
    repeat (170) @(posedge CLK);
    note_exp({2'h0, e}, {2'h0, m});
    line_done <= 1'b1;
    @(posedge CLK);
    line_done <= 1'b0;
  endtask

  function automatic logic [31:0] lr(input int w, input int r,
    input logic [3:0] ck, input int im, input logic cl, input logic fr);
    return {12'(w), 4'(r), ck, 4'h1, 4'(im), 2'h0, cl, fr};
  endfunction

  // Per-line blank measurement, sampled at the fourth cycle of each blank run
  always @(posedge CLK) begin
    if (rvalid && rready) pop_cmp({rresp, rdata});
    if (bvalid && bready) pop_cmp({bresp, 32'h0});
    if (line_done) begin
      pop_cmp({2'h0, m_w, m_r, m_ck, out_max, in_max, 2'h0, m_cl, m_fr});
      {m_w, m_r, m_ck, m_cl, m_fr, bcnt} = '0;
    end else if (hbw) begin
      m_w++;
      if (!pblank) m_r++;
      if (bcnt == 4'h3) {m_ck, m_cl, m_fr} = {hcc, obc, frz};
      if (bcnt != 4'hf) bcnt++;
    end else bcnt = 4'h0;
    pblank = hbw;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    {RESET, CLAMP_PATTERN} = 2'b11;
    {LINE_SYNC, FIELD_SYNC, SEQ_SEL, line_done} = '0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {m_w, m_r, m_ck, m_cl, m_fr, bcnt, pblank} = '0;
    rnd = $urandom(26);
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    axr(8'h36, {2'h0, 32'hfff});
    axr(8'h10, {2'h2, 32'h0});
    axw(8'h10, 32'h0, 2'h2);
    code = 3'($urandom);
    axw(8'h35, {25'h0, code, 4'h0});
    axr(8'h35, {2'h0, 25'h0, code, 4'h0});
    ta = '{20, 40, 60, 90, 100, 110, 30, 35, P, P, P, P};
    for (int a = 0; a < 4; a++) begin
      cfg(0, {1'b1, 3'(a)});
      field();
      line(0, lr(we[a], re[a], 0, 0, 1, a != 3), MA);
      line(0, lr(wo[a], ro[a], 0, 0, 1, a != 3), MA);
    end
    ta = '{5, 10, 12, 15, 20, 120, P, P, P, P, P, P};
    cfg(0, 4'hc);
    axw(8'h4d, 32'd20);
    axw(8'h4e, 32'd2);
    for (int a = 4; a < 8; a++) begin
      axw(8'h40, {28'h0, 1'b1, 3'(a)});
      line(0, lr(84, 5, 0, 0, 1, 1), MA);
    end
    ta = '{20, 80, P, P, P, P, P, P, P, P, P, P};
    cfg(0, 4'h8);
    for (int c = 0; c < 8; c++) begin
      axw(8'h35, {25'h0, 3'(c), 4'h0});
      line(0, lr(60, 1, 4'h5, 2 * c, 1, 1), c == 0 ? MCK : MIM);
    end
    axw(8'h40, 32'h0);
    axw(8'h35, 32'h0);
    line(0, lr(60, 1, 4'ha, 0, 1, 1), MCK);
    axw(8'h40, 32'h8);
    ta = '{10, 15, P, P, P, P, P, P, P, P, P, P};
    cfg(1, 4'h8);
    line(1, lr(5, 1, 0, 0, 1, 1), MA);
    line(0, lr(60, 1, 0, 0, 1, 1), MA);
    axw(8'h36, 32'h1);
    axw(8'h37, 32'h1);
    field();
    line(0, lr(60, 1, 0, 0, 1, 1), MA);
    line(0, lr(60, 1, 0, 0, 0, 1), MA);
    line(0, lr(60, 1, 0, 0, 1, 1), MA);
    axr(8'h38, {2'h0, 32'h0000_0002});
    axw(8'h36, 32'hfff);
    axw(8'h37, 32'hfff);
    for (int k = 0; k < 3; k++) begin
      t1 = 10 + $urandom % 40;
      t2 = t1 + 1 + $urandom % 60;
      ta = '{13'(t1), 13'(t2), P, P, P, P, P, P, P, P, P, P};
      cfg(0, 4'h8);
      line(0, lr(t2 - t1, 1, 0, 0, 1, 1), MA);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
